// File: shared/hpc_regs.svh
// timing counts, port count and default ids for the hub port power control
`ifndef HPC_REGS_SVH
`define HPC_REGS_SVH
`define HPC_CLK_HZ            20000000
`define HPC_OC_FILTER_NS      1000
`define HPC_OC_FILTER_CYC     ((`HPC_OC_FILTER_NS * (`HPC_CLK_HZ / 1000000) + 999) / 1000)
`define HPC_NUM_PORTS         4
`define HPC_PID_GENERIC       16'h0001
`define HPC_VID_GENERIC       16'h0001
`define HPC_LS_CHECK_CYC      4
`endif

// File: shared/hpc_pkg.sv
// types shared by the hub port power control
`default_nettype none
package hpc_pkg;
	typedef struct packed {
		logic gang_mode;
		logic bus_powered;
		logic ext_clock;
		logic rom_enable;
	} hpc_cfg_t;
	typedef enum logic [2:0] {
		HPC_CFG_WAIT = 3'b001,
		HPC_CFG_RUN  = 3'b010,
		HPC_CFG_SUSP = 3'b100
	} hpc_state_t;
endpackage : hpc_pkg
`default_nettype wire

// File: src/hpc_oc_filter.sv
// glitch filter for one active-low overcurrent input
`default_nettype none
`include "hpc_regs.svh"
module hpc_oc_filter #(
	parameter int FILTER_CYC = `HPC_OC_FILTER_CYC
) (
	input  wire logic sys_clk,
	input  wire logic reset,
	input  wire logic oc_n_async,
	output var  logic oc_event
);
	import hpc_pkg::*;
	logic       sync_a;
	logic       sync_b;
	logic [7:0] stable_cnt;
	always_ff @(posedge sys_clk) begin
		sync_a <= reset ? 1'b1 : oc_n_async;
		sync_b <= reset ? 1'b1 : sync_a;
	end
	// R5: spike rejection counter
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			stable_cnt <= 8'h00;
			oc_event   <= 1'b0;
		end else if (sync_b) begin
			stable_cnt <= 8'h00;
			oc_event   <= 1'b0;
		end else if (stable_cnt < 8'(FILTER_CYC - 1)) begin
			stable_cnt <= stable_cnt + 8'h01;
		end else begin
			oc_event <= 1'b1;
		end
	end
	property p_filter_min;
		@(posedge sys_clk) disable iff (reset) $rose(oc_event) |-> $past(!sync_b, FILTER_CYC);
	endproperty
	a_filter_min: assert property (p_filter_min) else $error("event without low input"); // R5
endmodule : hpc_oc_filter
`default_nettype wire

// File: src/hpc_port_power.sv
// strap capture, clock selection and downstream port power control
// How it works
// R1: gang strap high switches all ports together (code gangs only when memory_enable_strap_n is also high)
// R2: ganged overcurrent powers off every port
// R3: gang low handles each port separately
// R4: overcurrent is signalled by low input
// R5: overcurrent inputs are filtered against spikes
// R6: clock strap low selects pll clock
// R7: clock strap high selects external clock
// R8: oscillator powered down in external mode
// R9: crystal mode derives core clock from pll
// R10: rom strap high gives default identity
// R11: rom strap low uses rom ids, pins
// R12: power strap picks bus or self powered
// R13: port speed follows attached device speed
// R14: power enable outputs are active low
// R15: suspend status high only in suspend
// R16: straps stay fixed during operation
// R17: straps captured at reset release
`default_nettype none
`include "hpc_regs.svh"
module hpc_port_power #(
	parameter int NUM_PORTS  = `HPC_NUM_PORTS,
	parameter int FILTER_CYC = `HPC_OC_FILTER_CYC
) (
	input  wire logic                 sys_clk,
	input  wire logic                 reset,
	input  wire logic                 gang_strap,
	input  wire logic                 clock_mode_strap,
	input  wire logic                 memory_enable_strap_n,
	input  wire logic                 power_source_strap,
	input  wire logic [NUM_PORTS-1:0] port_overcurrent_n,
	input  wire logic [NUM_PORTS-1:0] port_power_request,
	input  wire logic [NUM_PORTS-1:0] port_low_speed_seen,
	input  wire logic                 suspend_request,
	input  wire logic [15:0]          rom_vid,
	input  wire logic [15:0]          rom_pid,
	output var  logic [NUM_PORTS-1:0] port_power_enable_n,
	output var  logic [NUM_PORTS-1:0] port_overcurrent_flag,
	output var  logic [NUM_PORTS-1:0] port_low_speed,
	output var  logic                 suspend_status,
	output var  logic                 analog_pll_power,
	output var  logic                 analog_pll_bypass,
	output var  logic                 crystal_osc_power,
	output var  logic                 core_clock_sel_ext,
	output var  logic                 serial_rom_clock_en,
	output var  logic                 serial_rom_data_en,
	output var  logic                 bus_powered,
	output var  logic [15:0]          hub_vid,
	output var  logic [15:0]          hub_pid,
	output var  hpc_pkg::hpc_cfg_t    cfg
);
	import hpc_pkg::*;
	logic [3:0]           strap_s1;
	logic [3:0]           strap_s2;
	hpc_state_t           state;
	hpc_state_t           next_state;
	logic [NUM_PORTS-1:0] oc_event;
	logic                 any_oc;
	logic                 susp_s1;
	logic                 susp_s2;
	// straps come from pins, two stages before use
	always_ff @(posedge sys_clk) begin
		strap_s1 <= {gang_strap, power_source_strap, clock_mode_strap, memory_enable_strap_n};
		strap_s2 <= strap_s1;
		susp_s1  <= suspend_request;
		susp_s2  <= susp_s1;
	end
	always_comb begin
		next_state = state;
		case (state)
			HPC_CFG_WAIT: next_state = HPC_CFG_RUN;
			HPC_CFG_RUN:  next_state = susp_s2 ? HPC_CFG_SUSP : HPC_CFG_RUN;
			HPC_CFG_SUSP: next_state = susp_s2 ? HPC_CFG_SUSP : HPC_CFG_RUN;
			default:      next_state = HPC_CFG_WAIT;
		endcase
	end
	always_ff @(posedge sys_clk) begin
		if (reset)
			state <= HPC_CFG_WAIT;
		else
			state <= next_state;
	end
	// R17: capture once after release
	// R16: later strap changes ignored
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cfg <= '0;
		end else if (state == HPC_CFG_WAIT) begin
			cfg.gang_mode   <= strap_s2[3] & strap_s2[0];
			cfg.bus_powered <= strap_s2[2];
			cfg.ext_clock   <= strap_s2[1];
			cfg.rom_enable  <= ~strap_s2[0];
		end
	end
	// R6: pll drives core when low
	// R7: external clock, pll bypassed
	// R8: oscillator off in external mode
	// R9: pll derives core clock from crystal
	always_ff @(posedge sys_clk) begin
		if (reset || state == HPC_CFG_WAIT) begin
			analog_pll_power   <= 1'b0;
			analog_pll_bypass  <= 1'b0;
			crystal_osc_power  <= 1'b0;
			core_clock_sel_ext <= 1'b0;
		end else begin
			analog_pll_power   <= ~cfg.ext_clock;
			analog_pll_bypass  <= cfg.ext_clock;
			crystal_osc_power  <= ~cfg.ext_clock;
			core_clock_sel_ext <= cfg.ext_clock;
		end
	end
	// R10: default identity, rom pins off
	// R11: rom pins and ids in use
	// R12: power mode from strap
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			serial_rom_clock_en <= 1'b0;
			serial_rom_data_en  <= 1'b0;
			bus_powered         <= 1'b0;
			hub_vid             <= `HPC_VID_GENERIC;
			hub_pid             <= `HPC_PID_GENERIC;
		end else begin
			serial_rom_clock_en <= cfg.rom_enable && state != HPC_CFG_WAIT;
			serial_rom_data_en  <= cfg.rom_enable && state != HPC_CFG_WAIT;
			bus_powered         <= cfg.bus_powered;
			hub_vid             <= cfg.rom_enable ? rom_vid : `HPC_VID_GENERIC;
			hub_pid             <= cfg.rom_enable ? rom_pid : `HPC_PID_GENERIC;
		end
	end
	// R15: suspend status output
	always_ff @(posedge sys_clk) begin
		if (reset)
			suspend_status <= 1'b0;
		else
			suspend_status <= (next_state == HPC_CFG_SUSP);
	end
	assign any_oc = |oc_event;
	genvar gi;
	generate
		for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
			logic ls_s1;
			logic ls_s2;
			// R4: low input means overcurrent
			// R5: filter per input
			hpc_oc_filter #(
				.FILTER_CYC (FILTER_CYC)
			) u_filter (
				.sys_clk    (sys_clk),
				.reset      (reset),
				.oc_n_async (port_overcurrent_n[gi]),
				.oc_event   (oc_event[gi])
			);
			always_ff @(posedge sys_clk) begin
				ls_s1 <= port_low_speed_seen[gi];
				ls_s2 <= ls_s1;
			end
			// R13: speed follows attached device
			always_ff @(posedge sys_clk) begin
				if (reset)
					port_low_speed[gi] <= 1'b0;
				else
					port_low_speed[gi] <= ls_s2;
			end
			// R1: ganged ports switch together
			// R2: any overcurrent cuts all ports
			// R3: per-port power and overcurrent
			// R14: low level turns power on
			always_ff @(posedge sys_clk) begin
				if (reset || state == HPC_CFG_WAIT) begin
					port_power_enable_n[gi]   <= 1'b1;
					port_overcurrent_flag[gi] <= 1'b0;
				end else if (cfg.gang_mode) begin
					port_power_enable_n[gi]   <= any_oc | ~port_power_request[0];
					port_overcurrent_flag[gi] <= any_oc;
				end else begin
					port_power_enable_n[gi]   <= oc_event[gi] | ~port_power_request[gi];
					port_overcurrent_flag[gi] <= oc_event[gi];
				end
			end
		end
	endgenerate
	property p_gang_equal;
		@(posedge sys_clk) disable iff (reset)
			cfg.gang_mode && state != HPC_CFG_WAIT |=> (&port_power_enable_n) || !(|port_power_enable_n);
	endproperty
	a_gang_equal: assert property (p_gang_equal) else $error("ganged outputs differ"); // R1
	property p_gang_oc;
		@(posedge sys_clk) disable iff (reset)
			cfg.gang_mode && any_oc && state != HPC_CFG_WAIT |=> &port_power_enable_n;
	endproperty
	a_gang_oc: assert property (p_gang_oc) else $error("ganged overcurrent left power on"); // R2
	property p_port_oc;
		@(posedge sys_clk) disable iff (reset)
			!cfg.gang_mode && oc_event[0] && state != HPC_CFG_WAIT |=> port_power_enable_n[0];
	endproperty
	a_port_oc: assert property (p_port_oc) else $error("port overcurrent left power on"); // R3
	property p_pll_sel;
		@(posedge sys_clk) disable iff (reset)
			state == HPC_CFG_RUN && !cfg.ext_clock |=> analog_pll_power && !core_clock_sel_ext;
	endproperty
	a_pll_sel: assert property (p_pll_sel) else $error("pll not selected"); // R6
	property p_ext_sel;
		@(posedge sys_clk) disable iff (reset)
			state == HPC_CFG_RUN && cfg.ext_clock |=> analog_pll_bypass && !analog_pll_power;
	endproperty
	a_ext_sel: assert property (p_ext_sel) else $error("external clock not selected"); // R7
	property p_osc_off;
		@(posedge sys_clk) disable iff (reset) cfg.ext_clock |=> !crystal_osc_power;
	endproperty
	a_osc_off: assert property (p_osc_off) else $error("oscillator on in external mode"); // R8
	property p_default_id;
		@(posedge sys_clk) disable iff (reset)
			!cfg.rom_enable |=> hub_pid == `HPC_PID_GENERIC && !serial_rom_clock_en;
	endproperty
	a_default_id: assert property (p_default_id) else $error("default identity lost"); // R10
	property p_capture_hold;
		@(posedge sys_clk) disable iff (reset) state != HPC_CFG_WAIT |=> $stable(cfg);
	endproperty
	a_capture_hold: assert property (p_capture_hold) else $error("config changed"); // R16
	property p_suspend;
		@(posedge sys_clk) disable iff (reset) suspend_status == (state == HPC_CFG_SUSP);
	endproperty
	a_suspend: assert property (p_suspend) else $error("suspend status wrong"); // R15
	c_gang_oc: cover property (@(posedge sys_clk) cfg.gang_mode && any_oc);
	c_port_oc: cover property (@(posedge sys_clk) !cfg.gang_mode && oc_event[1]);
	c_suspend: cover property (@(posedge sys_clk) state == HPC_CFG_SUSP);
	c_rom_id:  cover property (@(posedge sys_clk) cfg.rom_enable && state == HPC_CFG_RUN);
endmodule : hpc_port_power
`default_nettype wire

// File: dv/hpc_power_switch_model.sv
// external power switch model that reports port faults
`default_nettype none
module hpc_power_switch_model #(
	parameter int NUM_PORTS = 4
) (
	input  wire logic [NUM_PORTS-1:0] fault,
	input  wire logic [NUM_PORTS-1:0] port_power_enable_n,
	output var  logic [NUM_PORTS-1:0] port_overcurrent_n,
	output var  logic [NUM_PORTS-1:0] port_powered
);
	timeunit 1ns;
	timeprecision 1ns;
	always_comb port_overcurrent_n = ~fault;
	always_comb port_powered = ~port_power_enable_n;
endmodule : hpc_power_switch_model
`default_nettype wire

// File: dv/tb_hpc_port_power.sv
// self-checking bench for the hub port power control
`default_nettype none
`include "hpc_regs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
	$display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end
module tb_hpc_port_power;
	timeunit 1ns;
	timeprecision 1ns;
	import hpc_pkg::*;
	localparam int FC = 4;
	logic       sys_clk, reset, gang, clkm, mem_n, psrc, susp, susp_st;
	logic       pllp, pllb, oscp, sel, romc, romd, busp;
	logic [3:0] req, ls, fault, oc_n, en_n, flag, lso, powered;
	logic [15:0] rvid, rpid, vid, pid;
	hpc_cfg_t   cfg;
	int         err_count, tests_run;

	hpc_port_power #(.NUM_PORTS(4), .FILTER_CYC(FC)) hpc_port_power_inst (
		.sys_clk(sys_clk), .reset(reset), .gang_strap(gang), .clock_mode_strap(clkm),
		.memory_enable_strap_n(mem_n), .power_source_strap(psrc),
		.port_overcurrent_n(oc_n), .port_power_request(req), .port_low_speed_seen(ls),
		.suspend_request(susp), .rom_vid(rvid), .rom_pid(rpid),
		.port_power_enable_n(en_n), .port_overcurrent_flag(flag), .port_low_speed(lso),
		.suspend_status(susp_st), .analog_pll_power(pllp), .analog_pll_bypass(pllb),
		.crystal_osc_power(oscp), .core_clock_sel_ext(sel), .serial_rom_clock_en(romc),
		.serial_rom_data_en(romd), .bus_powered(busp), .hub_vid(vid), .hub_pid(pid),
		.cfg(cfg));

	hpc_power_switch_model #(.NUM_PORTS(4)) hpc_power_switch_model_inst (
		.fault(fault), .port_power_enable_n(en_n), .port_overcurrent_n(oc_n),
		.port_powered(powered));

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : cyc

	// straps held fixed
	// straps held steady through reset, captured on release
	task automatic start(input logic g, input logic c, input logic m, input logic p);
		reset = 1'b1;
		{gang, clkm, mem_n, psrc} = {g, c, m, p};
		cyc(4);
		`CHK(en_n, 4'hf)
		reset = 1'b0;
		cyc(4);
	endtask : start

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report

	// hang guard, far beyond the roughly 90 cycles of the sequence
	initial begin
		#200000;
		err_count++;
		final_report();
	end

	initial begin
		err_count = 0;
		tests_run = 0;
		reset = 1'b1;
		{gang, clkm, mem_n, psrc, susp} = 5'h00;
		{req, ls, fault} = 12'h000;
		rvid = 16'h1234;
		rpid = 16'h5678;
		@(negedge sys_clk);
		start(1'b1, 1'b0, 1'b1, 1'b1);
		`CHK(cfg, hpc_cfg_t'(4'b1100))
		`CHK({pllp, pllb, oscp, sel}, 4'ha)
		`CHK({romc, romd, busp}, 3'b001)
		`CHK({vid, pid}, {`HPC_VID_GENERIC, `HPC_PID_GENERIC})
		req = 4'h1;
		cyc(4);
		`CHK(en_n, 4'h0)
		// one-cycle spike must be swallowed
		fault = 4'h2;
		cyc(1);
		fault = 4'h0;
		cyc(FC + 6);
		`CHK(en_n, 4'h0)
		fault = 4'h4;
		cyc(FC + 6);
		`CHK(en_n, 4'hf)
		`CHK(flag, 4'hf)
		fault = 4'h0;
		cyc(FC + 6);
		`CHK(en_n, 4'h0)
		{gang, clkm, mem_n, psrc} = 4'b0100;
		cyc(6);
		`CHK(cfg, hpc_cfg_t'(4'b1100))
		`CHK({pllp, sel, busp}, 3'b101)
		// rom in use, so the gang strap is not honoured
		start(1'b1, 1'b1, 1'b0, 1'b0);
		`CHK(cfg, hpc_cfg_t'(4'b0011))
		`CHK({pllp, pllb, oscp, sel}, 4'h5)
		`CHK({romc, romd, busp}, 3'b110)
		`CHK({vid, pid}, {rvid, rpid})
		req = 4'h5;
		cyc(4);
		`CHK(en_n, 4'ha)
		fault = 4'h1;
		cyc(FC + 6);
		`CHK(en_n, 4'hb)
		`CHK(flag, 4'h1)
		`CHK(powered, 4'h4)
		fault = 4'h3;
		cyc(FC + 6);
		`CHK(flag, 4'h3)
		`CHK(en_n, 4'hb)
		{ls, susp} = 5'h13;
		cyc(4);
		`CHK(lso, 4'h9)
		`CHK(susp_st, 1'b1)
		susp = 1'b0;
		cyc(4);
		`CHK(susp_st, 1'b0)
		final_report();
	end
endmodule : tb_hpc_port_power
`default_nettype wire
